// ==== hdl/vmc_pkg.sv ====
package vmc_pkg;

    localparam logic [15:0] SEQ_INDEX_PORT   = 16'h03C4;
    localparam logic [15:0] SEQ_DATA_PORT    = 16'h03C5;
    localparam logic [15:0] TIM_INDEX_MONO   = 16'h03B4;
    localparam logic [15:0] TIM_DATA_MONO    = 16'h03B5;
    localparam logic [15:0] TIM_INDEX_COLOR  = 16'h03D4;
    localparam logic [15:0] TIM_DATA_COLOR   = 16'h03D5;

    localparam logic [7:0]  SEQ_IDX_MEM_MODE = 8'h04;
    localparam logic [5:0]  TIM_IDX_HTOTAL   = 6'h00;

    localparam int          MM_EXT_BIT       = 1;
    localparam int          MM_OE_BIT        = 2;
    localparam int          MM_CHAIN_BIT     = 3;
    localparam logic [7:0]  MM_WRITE_MASK    = 8'h0E;
    localparam logic [7:0]  MM_RESET         = 8'h00;
    localparam logic [5:0]  TIM_INDEX_RESET  = 6'h00;
    localparam logic [7:0]  HTOTAL_RESET     = 8'h00;

    localparam logic [7:0]  HTOTAL_BIAS      = 8'h05;
    localparam logic [15:0] SMALL_MEM_MASK   = 16'hFFFF;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } vmc_io_req_t;

    typedef struct packed {
        logic [3:0]  plane_en;
        logic [1:0]  read_plane;
        logic [21:0] offset;
    } vmc_map_t;

endpackage

// ==== hdl/vmc_top.sv ====
// Summary of operation
// - Chaining bit set overrides the sequencer alternating-plane setting; the graphics alternating-plane input is not used.
// - In chained mode plane select comes from CPU address bits A0, A1.
// - In chained mode the read plane select register is ignored.
// - Alternating-plane bit at zero selects alternating mode unless chaining overrides.
// - Alternating mode: even addresses reach planes 0,2; odd reach 1,3.
// - Extended-memory bit zero limits memory to 64 Kbytes; one uses all.
// - Six-bit timing index selects register reached by next data-port access.
// - Timing ports decode at 3B4/3B5 monochrome, 3D4/3D5 color.
// - Line-total writes are blocked while the protect bit is set.
// - Character clock from pixel clock by character width, counted, compared.
// - Line total is eight bits, programmed as total characters minus five.
// - Horizontal timing counts characters; vertical counts lines.
// - Chaining, alternating, extended and index bits reset to zero.
`timescale 1ns/1ps
`default_nettype none

module vmc_top #(
    parameter int ADDR_W = 22,
    parameter int LINE_W = 11
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               clk_en,
    input  wire vmc_pkg::vmc_io_req_t io_req,
    output logic [7:0]              io_rdata,
    output logic                    io_hit,
    input  wire logic               color_mode,
    input  wire logic               write_protect,
    input  wire logic [7:0]         seq_index,
    input  wire logic               gfx_odd_even,
    input  wire logic [1:0]         read_plane_select,
    input  wire logic [ADDR_W-1:0]  cpu_addr,
    input  wire logic [21:0]        installed_mask,
    output vmc_pkg::vmc_map_t       mem_map,
    input  wire logic               pixel_clock_in,
    input  wire logic               char_width_9,
    output logic                    char_tick,
    output logic                    line_tick,
    output logic [7:0]              char_count,
    output logic [LINE_W-1:0]       line_count
);

    logic [7:0]        memory_mode_ff;
    logic [5:0]        timing_index_ff;
    logic [7:0]        line_total_ff;
    logic              pix_s1_ff;
    logic              pix_s2_ff;
    logic              pix_s3_ff;
    logic [3:0]        dot_ff;
    logic [7:0]        char_ff;
    logic [LINE_W-1:0] line_ff;
    logic [7:0]        rdata_ff;

    wire [15:0] tim_idx_port = color_mode ? vmc_pkg::TIM_INDEX_COLOR
                                          : vmc_pkg::TIM_INDEX_MONO;
    wire [15:0] tim_dat_port = color_mode ? vmc_pkg::TIM_DATA_COLOR
                                          : vmc_pkg::TIM_DATA_MONO;
    wire hit_mm  = (io_req.addr == vmc_pkg::SEQ_DATA_PORT)
                   && (seq_index == vmc_pkg::SEQ_IDX_MEM_MODE);
    wire hit_idx = io_req.addr == tim_idx_port;
    wire hit_ht  = (io_req.addr == tim_dat_port)
                   && (timing_index_ff == vmc_pkg::TIM_IDX_HTOTAL);
    wire wr_mm   = clk_en && io_req.wr && hit_mm;
    wire wr_idx  = clk_en && io_req.wr && hit_idx;
    wire wr_ht   = clk_en && io_req.wr && hit_ht && !write_protect;

    wire chain   = memory_mode_ff[vmc_pkg::MM_CHAIN_BIT];
    wire odd_ev  = !memory_mode_ff[vmc_pkg::MM_OE_BIT] && !chain;
    wire ext_mem = memory_mode_ff[vmc_pkg::MM_EXT_BIT];

    // Reserved bits are never stored, so they cannot steer anything.
    wire [7:0] nxt_memory_mode = io_req.wdata & vmc_pkg::MM_WRITE_MASK;

    // Plane enables by mapping mode; linear mode enables all four.
    wire [3:0] plane_chain = 4'h1 << cpu_addr[1:0];
    wire [3:0] plane_oe    = cpu_addr[0] ? 4'hA : 4'h5;
    wire [3:0] nxt_planes  = chain ? plane_chain : (odd_ev ? plane_oe : 4'hF);
    wire [1:0] nxt_rplane  = chain ? cpu_addr[1:0] : read_plane_select;
    // Chained and alternating modes consume low address bits for plane select.
    wire [21:0] raw_off   = 22'(chain ? (cpu_addr >> 2) : (odd_ev ? (cpu_addr >> 1) : cpu_addr));
    wire [21:0] limit     = ext_mem ? installed_mask
                                    : {6'h00, vmc_pkg::SMALL_MEM_MASK};
    wire [21:0] nxt_off   = raw_off & limit;

    // Counter ends at total plus bias so the line spans programmed plus five characters.
    wire [7:0] ht_end    = line_total_ff + vmc_pkg::HTOTAL_BIAS;
    wire       pix_rise  = pix_s2_ff && !pix_s3_ff;
    wire [3:0] dot_last  = char_width_9 ? 4'h8 : 4'h7;
    wire       nxt_char_tick = pix_rise && (dot_ff == dot_last);
    wire       at_end    = char_ff >= ht_end - 8'h01;
    wire       nxt_line_tick = nxt_char_tick && at_end;

    wire [7:0] nxt_rdata = hit_mm  ? memory_mode_ff :
                           hit_idx ? {2'b00, timing_index_ff} :
                           hit_ht  ? line_total_ff : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            memory_mode_ff  <= vmc_pkg::MM_RESET;
            timing_index_ff <= vmc_pkg::TIM_INDEX_RESET;
            line_total_ff   <= vmc_pkg::HTOTAL_RESET;
        end else begin
            if (wr_mm) begin
                memory_mode_ff <= nxt_memory_mode;
            end
            if (wr_idx) begin
                timing_index_ff <= io_req.wdata[5:0];
            end
            if (wr_ht) begin
                line_total_ff <= io_req.wdata;
            end
        end
    end

    // The pixel clock is slow against clk here, so it is sampled as a level.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pix_s1_ff <= 1'b0;
            pix_s2_ff <= 1'b0;
            pix_s3_ff <= 1'b0;
        end else if (clk_en) begin
            pix_s1_ff <= pixel_clock_in;
            pix_s2_ff <= pix_s1_ff;
            pix_s3_ff <= pix_s2_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dot_ff  <= 4'h0;
            char_ff <= 8'h00;
            line_ff <= '0;
        end else if (clk_en && pix_rise) begin
            dot_ff <= nxt_char_tick ? 4'h0 : dot_ff + 4'h1;
            if (nxt_char_tick) begin
                char_ff <= at_end ? 8'h00 : char_ff + 8'h01;
                if (at_end) begin
                    line_ff <= line_ff + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff   <= 8'h00;
            char_tick  <= 1'b0;
            line_tick  <= 1'b0;
            mem_map    <= '0;
        end else if (clk_en) begin
            rdata_ff   <= io_req.rd ? nxt_rdata : rdata_ff;
            char_tick  <= nxt_char_tick;
            line_tick  <= nxt_line_tick;
            mem_map    <= '{plane_en: nxt_planes, read_plane: nxt_rplane, offset: nxt_off};
        end
    end

    assign io_rdata   = rdata_ff;
    assign io_hit     = hit_mm || hit_idx || hit_ht;
    assign char_count = char_ff;
    assign line_count = line_ff;

    chain_planes_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && chain |=> mem_map.plane_en == (4'h1 << $past(cpu_addr[1:0])))
        else $error("Chained plane select wrong.");
    chain_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && chain |=> mem_map.read_plane == $past(cpu_addr[1:0]))
        else $error("Chained read plane wrong.");
    odd_even_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && odd_ev |=> mem_map.plane_en == ($past(cpu_addr[0]) ? 4'hA : 4'h5))
        else $error("Alternating planes wrong.");
    override_a: assert property (@(posedge clk) disable iff (!rst_n)
        chain |-> !odd_ev)
        else $error("Chaining did not override.");
    small_mem_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !ext_mem |=> mem_map.offset[21:16] == 6'h00)
        else $error("Memory not limited.");
    protect_a: assert property (@(posedge clk) disable iff (!rst_n)
        write_protect |=> $stable(line_total_ff))
        else $error("Protected write landed.");
    index_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_idx |=> timing_index_ff == $past(io_req.wdata[5:0]))
        else $error("Index not stored.");
    line_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && pix_rise && nxt_line_tick |=> char_ff == 8'h00 && line_tick)
        else $error("Line wrap wrong.");
    reset_val_a: assert property (@(posedge clk)
        !rst_n |=> memory_mode_ff == 8'h00 && timing_index_ff == 6'h00)
        else $error("Reset values wrong.");

    // The port digit is checked on the raw address, so a decode slip cannot hide behind itself.
    mono_port_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit_idx |-> io_req.addr[7:4] == (color_mode ? 4'hD : 4'hB))
        else $error("Index port digit wrong.");
    read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && io_req.rd && hit_idx |=> io_rdata == {2'b00, $past(timing_index_ff)})
        else $error("Index read back wrong.");
    ht_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ht |=> line_total_ff == $past(io_req.wdata))
        else $error("Line total not stored.");
    reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
        memory_mode_ff[7:4] == 4'h0 && !memory_mode_ff[0])
        else $error("Reserved bits stored.");
    tick_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        line_tick |-> char_tick && char_count == 8'h00)
        else $error("Line tick without wrap.");
    freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
        !clk_en |=> $stable(char_ff) && $stable(memory_mode_ff))
        else $error("State moved while frozen.");

    line_seen_c: cover property (@(posedge clk) disable iff (!rst_n) line_tick);
    chain_use_c: cover property (@(posedge clk) disable iff (!rst_n) wr_mm ##1 chain);
    odd_even_c:  cover property (@(posedge clk) disable iff (!rst_n) clk_en && odd_ev);
    protect_c:   cover property (@(posedge clk) disable iff (!rst_n)
        write_protect && io_req.wr && hit_ht);

endmodule

`default_nettype wire

// ==== verif/vmc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host CPU side: one-cycle I/O strobes, launched just after a rising edge.
module vmc_host_model (
    input  wire logic            clk,
    input  wire logic [7:0]      io_rdata,
    output vmc_pkg::vmc_io_req_t io_req,
    output logic                 gfx_odd_even
);
    initial begin
        io_req = '0;
        gfx_odd_even = 1'b1;
    end
    // Only text-free plane modes are set up here, so the alternating bit is free to move.
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        if (a == vmc_pkg::SEQ_DATA_PORT) gfx_odd_even <= ~d[vmc_pkg::MM_OE_BIT];
        @(posedge clk);
        io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic io_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
        #1 d = io_rdata;
    endtask
endmodule
`default_nettype wire

// ==== verif/vmc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module vmc_top_tb;
    logic                 clk, rst_n, color_mode, write_protect, cw9, pix, gfx_oe, ce;
    logic                 io_hit, char_tick, line_tick;
    logic [1:0]           rps;
    logic [21:0]          cpu_addr;
    logic [7:0]           io_rdata, char_count, rd;
    logic [10:0]          line_count, lc0;
    vmc_pkg::vmc_io_req_t io_req;
    vmc_pkg::vmc_map_t    mem_map;
    int                   error_cnt = 0, compares = 0, n;
    vmc_host_model HOST (.clk(clk), .io_rdata(io_rdata), .io_req(io_req), .gfx_odd_even(gfx_oe));
    vmc_top DUT (.clk(clk), .rst_n(rst_n), .clk_en(ce), .io_req(io_req), .io_rdata(io_rdata),
        .io_hit(io_hit), .color_mode(color_mode), .write_protect(write_protect),
        .seq_index(8'h04), .gfx_odd_even(gfx_oe), .read_plane_select(rps), .cpu_addr(cpu_addr),
        .installed_mask(22'h3FFFFF), .mem_map(mem_map), .pixel_clock_in(pix),
        .char_width_9(cw9), .char_tick(char_tick), .line_tick(line_tick),
        .char_count(char_count), .line_count(line_count));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Pixel clock well under half the system clock, as the synchroniser needs.
    initial begin
        pix = 1'b0;
        forever #300 pix = ~pix;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        HOST.io_read(a, rd);
        check(what, {24'h0, exp}, {24'h0, rd});
    endtask
    task automatic map(input logic [21:0] a);
        @(posedge clk);
        cpu_addr <= a;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Outputs are looked at 1 ns after the edge, once the edge's updates have settled.
    task automatic wait_line;
        for (n = 0; n < 3000; n++) begin
            @(posedge clk);
            #1;
            if (line_tick === 1'b1) break;
        end
        if (n == 3000) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic t_planes;
        rd_chk("mm reset", vmc_pkg::SEQ_DATA_PORT, 8'h00);
        HOST.io_write(vmc_pkg::SEQ_DATA_PORT, 8'hFF);
        rd_chk("mm reserved", vmc_pkg::SEQ_DATA_PORT, 8'h0E);
        rps <= 2'h1;
        map(22'h000006);
        check("chain map", {4'h4, 2'h2, 22'h1}, mem_map);
        HOST.io_write(vmc_pkg::SEQ_DATA_PORT, 8'h02);
        map(22'h000005);
        check("oe odd", {4'hA, 22'h2}, {mem_map.plane_en, mem_map.offset});
        HOST.io_write(vmc_pkg::SEQ_DATA_PORT, 8'h04);
        map(22'h2ABCDE);
        check("small mem", {4'hF, 22'h00BCDE}, {mem_map.plane_en, mem_map.offset});
        HOST.io_write(vmc_pkg::SEQ_DATA_PORT, 8'h06);
        map(22'h2ABCDE);
        check("full mem", 22'h2ABCDE, mem_map.offset);
    endtask
    task automatic t_ports;
        ce <= 1'b0;
        HOST.io_write(vmc_pkg::TIM_INDEX_COLOR, 8'h05);
        ce <= 1'b1;
        rd_chk("frozen index", vmc_pkg::TIM_INDEX_COLOR, 8'h00);
        HOST.io_write(vmc_pkg::TIM_INDEX_COLOR, 8'hC0);
        rd_chk("index six bits", vmc_pkg::TIM_INDEX_COLOR, 8'h00);
        HOST.io_write(vmc_pkg::TIM_DATA_COLOR, 8'h4B);
        color_mode <= 1'b0;
        fork
            rd_chk("mono data", vmc_pkg::TIM_DATA_MONO, 8'h4B);
            begin
                @(posedge clk);
                #1 check("hit mono", 32'd1, {31'h0, io_hit});
            end
        join
        fork
            rd_chk("color off", vmc_pkg::TIM_DATA_COLOR, 8'h00);
            begin
                @(posedge clk);
                #1 check("hit color off", 32'd0, {31'h0, io_hit});
            end
        join
        write_protect <= 1'b1;
        HOST.io_write(vmc_pkg::TIM_DATA_MONO, 8'h11);
        rd_chk("protected", vmc_pkg::TIM_DATA_MONO, 8'h4B);
        write_protect <= 1'b0;
        HOST.io_write(vmc_pkg::TIM_DATA_MONO, 8'h00);
    endtask
    task automatic t_timing;
        int ticks;
        int gap;
        wait_line();
        lc0 = line_count;
        check("count restart", 8'h00, char_count);
        ticks = 0;
        for (n = 0; n < 3000; n++) begin
            @(posedge clk);
            #1;
            if (char_tick === 1'b1) ticks++;
            if (line_tick === 1'b1) break;
        end
        if (n == 3000) begin
            error_cnt++;
            give_verdict();
        end
        check("chars per line", 32'd5, ticks);
        check("line advance", lc0 + 11'd1, line_count);
        // Pixel period is six system clocks, so nine dots span 54 cycles.
        @(posedge clk);
        cw9 <= 1'b1;
        ticks = 0;
        gap = 0;
        for (n = 0; n < 3000 && ticks < 3; n++) begin
            @(posedge clk);
            #1;
            if (ticks == 2) gap++;
            if (char_tick === 1'b1) ticks++;
        end
        if (ticks < 3) begin
            error_cnt++;
            give_verdict();
        end
        check("nine dot char", 32'd54, gap);
    endtask
    initial begin
        rst_n = 1'b0;
        color_mode = 1'b1;
        write_protect = 1'b0;
        cw9 = 1'b0;
        ce = 1'b1;
        rps = 2'h0;
        cpu_addr = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_planes();
        t_ports();
        t_timing();
        give_verdict();
    end
endmodule
`default_nettype wire
